// ### bench/dio_input_capture_start_control_test.sv
// Purpose: Self-checking bench for the capture and start-control block
// Assumes: Register port answers one cycle after the read strobe
// Notes: Sample counts allow a few clocks of synchroniser slack
`timescale 1ns/100ps
`default_nettype none
`define CHK(a, b) begin total_checks++; if ((a) !== (b)) begin error_cnt++; $display("BAD %0t got %h exp %h", $time, a, b); end end
module dio_input_capture_start_control_test;
  logic clk_i = 1'b0;
  logic sys_rst_i = 1'b1;
  logic [3:0] addr_i = 4'h0;
  logic [31:0] wdata_i = 32'h0;
  logic wr_i = 1'b0;
  logic rd_i = 1'b0;
  logic [31:0] rdata_o, di_data, base = 32'h0, s, r;
  logic strobe, ack, term_en_o, do_run_o, hs = 1'b0, rdy = 1'b0;
  logic trig_in = 1'b0, trig_out = 1'b0, tmr = 1'b0;
  logic [15:0] lvl = 16'h0, target = 16'h0, sent, s0;
  logic [1:0] rdy_mode = 2'h0;
  dio_capture_pkg::dma_word_t dma_o;
  int error_cnt = 0, total_checks = 0, cyc = 0, cnt;
  logic [31:0] rxq[$];
  logic [3:0] a_tbl[5] = '{4'h0, 4'h8, 4'hC, 4'h4, 4'h2};
  logic [31:0] e_tbl[5] = '{32'h40, 32'h100, 32'h0, 32'h0, 32'h0};

  always #25 clk_i = ~clk_i;

  dio_input_capture_start_control u_dio_input_capture_start_control (.clk_i(clk_i), .sys_rst_i(sys_rst_i),
    .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .di_data_i(di_data),
    .input_request_strobe_i(strobe), .input_trigger_line_i(trig_in), .output_trigger_line_i(trig_out),
    .timer0_i(tmr), .input_acknowledge_o(ack), .term_en_o(term_en_o), .do_fifo_level_i(lvl),
    .do_run_o(do_run_o), .dma_ready_i(rdy), .dma_o(dma_o));
  dio_periph_model u_dio_periph_model (.hs_i(hs), .target_i(target), .base_i(base), .ack_i(ack),
    .strobe_o(strobe), .data_o(di_data), .sent_o(sent));

  // ==========================================
  // DMA side: ready pattern, word capture, hang guard
  always @(posedge clk_i) begin
    rdy <= (rdy_mode == 2'h2) ? 1'($urandom) : rdy_mode[0];
    if (dma_o.valid === 1'b1 && rdy === 1'b1) rxq.push_back(dma_o.data);
    cyc++;
    if (cyc == 60000) begin
      error_cnt++;
      print_verdict();
    end
  end

  task automatic print_verdict();
    $display("checks %0d mismatches %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask

  // ==========================================
  // Register port cycles
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge clk_i);
    addr_i <= a;
    wdata_i <= d;
    wr_i <= 1'b1;
    @(posedge clk_i);
    wr_i <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a, output logic [31:0] d);
    @(posedge clk_i);
    addr_i <= a;
    rd_i <= 1'b1;
    @(posedge clk_i);
    rd_i <= 1'b0;
    #1 d = rdata_o; // Valid only in the cycle after the strobe
  endtask
  task automatic cmd(input int b);
    wr(dio_capture_pkg::CMD_OFS, 32'h1 << b);
  endtask
  task automatic wt(input int n);
    repeat (n) @(posedge clk_i);
  endtask
  task automatic flush();
    rdy_mode = 2'h1;
    cmd(dio_capture_pkg::CMD_DI_STOP);
    cmd(dio_capture_pkg::CMD_FLUSH);
    cmd(dio_capture_pkg::CMD_OVR_CLR);
    wt(10);
    rxq.delete();
  endtask
  function automatic logic [31:0] mk(input int w, input int m, input int p, input int i, input int o);
    dio_capture_pkg::ctrl_t c;
    c = '0;
    c.width = dio_capture_pkg::width_t'(w);
    c.clk_mode = dio_capture_pkg::clk_mode_t'(m);
    c.pacer = dio_capture_pkg::pacer_t'(p);
    c.in_start = dio_capture_pkg::start_t'(i);
    c.out_start = dio_capture_pkg::start_t'(o);
    c.rising = 1'b1;
    return c;
  endfunction
  function automatic logic [31:0] exp_word(input logic [15:0] n, input int w);
    logic [31:0] v;
    v = base + n * 32'h01010101;
    return (w == 2) ? (v & 32'hFF) : (w == 1) ? (v & 32'hFFFF) : v;
  endfunction
  // Pacer run: count lands inside [lo, hi]
  task automatic pace(input int p, input int n, input int lo, input int hi);
    flush();
    rdy_mode = 2'h0;
    wr(dio_capture_pkg::CTRL_OFS, mk(0, 0, p, 0, 0));
    cmd(dio_capture_pkg::CMD_DI_START);
    if (p == 2) repeat (n) begin
      tmr <= 1'b1;
      wt(4);
      tmr <= 1'b0;
      wt(4);
    end else wt(n);
    cmd(dio_capture_pkg::CMD_DI_STOP);
    rd(dio_capture_pkg::STAT_OFS, s);
    cnt = int'(s[30:16]);
    `CHK(cnt >= lo && cnt <= hi, 1'b1)
  endtask

  initial begin
    r = $urandom(32'hc9343551);
    wt(12);
    sys_rst_i <= 1'b0;
    `CHK(term_en_o, 1'b0)
    for (int k = 0; k < 5; k++) begin
      rd(a_tbl[k], s);
      `CHK(s, e_tbl[k])
    end
    wr(dio_capture_pkg::CTRL_OFS, 32'h840);
    wt(2);
    `CHK(term_en_o, 1'b1)
    $display("test registers done");
    // Streams: external strobe at every width, then handshake
    for (int k = 0; k < 5; k++) begin
      flush();
      hs = (k > 2);
      base = $urandom;
      wr(dio_capture_pkg::CTRL_OFS, mk(k % 3, hs ? 2 : 1, 0, 0, 0) ^ ((k == 1) ? 32'h0000_0040 : 32'h0000_0000));
      rdy_mode = 2'h2;
      cmd(dio_capture_pkg::CMD_DI_START);
      s0 = sent;
      target <= sent + 16'd20;
      for (int t = 0; t < 900 && rxq.size() < 20; t++) @(posedge clk_i);
      `CHK(rxq.size(), 20)
      for (int i = 0; i < rxq.size(); i++) `CHK(rxq[i], exp_word(s0 + 16'(i), k % 3))
    end
    $display("test streams done");
    // Input start codes
    for (int c = 0; c < 4; c++) begin
      flush();
      wr(dio_capture_pkg::CTRL_OFS, mk(0, 0, 0, c, 0));
      cmd(dio_capture_pkg::CMD_DI_START);
      wt(3);
      rd(dio_capture_pkg::STAT_OFS, s);
      `CHK(s[2:1], (c == 1) ? 2'b10 : 2'b01)
      trig_in <= 1'b1;
      wt(4);
      trig_in <= 1'b0;
      wt(4);
      rd(dio_capture_pkg::STAT_OFS, s);
      `CHK(s[1], 1'b1)
    end
    $display("test input start done");
    // Output start codes, level boundary at the threshold
    wr(dio_capture_pkg::THR_OFS, 32'h40);
    for (int c = 0; c < 4; c++) begin
      lvl <= 16'h3F;
      wr(dio_capture_pkg::CTRL_OFS, mk(0, 0, 0, 0, c));
      cmd(dio_capture_pkg::CMD_DO_START);
      wt(8);
      `CHK(do_run_o, c == 0)
      lvl <= 16'h40;
      wt(4);
      `CHK(do_run_o, c == 0 || c == 2)
      trig_out <= 1'b1;
      wt(4);
      trig_out <= 1'b0;
      wt(6);
      `CHK(do_run_o, 1'b1)
      cmd(dio_capture_pkg::CMD_DO_STOP);
    end
    $display("test output start done");
    pace(0, 100, 97, 104);
    pace(1, 100, 47, 54);
    pace(2, 6, 5, 6);
    $display("test pacer done");
    // Fill with DMA stalled, then overrun, clear and acknowledge
    pace(0, 16500, 16383, 16384);
    rd(dio_capture_pkg::STAT_OFS, s);
    `CHK({s[4], s[0]}, 2'b11)
    wt(20);
    rd(dio_capture_pkg::STAT_OFS, s);
    `CHK(s[0], 1'b1)
    cmd(dio_capture_pkg::CMD_OVR_CLR);
    rd(dio_capture_pkg::STAT_OFS, s);
    `CHK({s[4], s[0]}, 2'b10)
    hs = 1'b0;
    wr(dio_capture_pkg::CTRL_OFS, mk(0, 1, 0, 0, 0));
    cmd(dio_capture_pkg::CMD_DI_START);
    wt(4);
    `CHK(ack, 1'b0)
    rdy_mode = 2'h1;
    wt(40);
    `CHK(ack, 1'b1)
    flush();
    $display("test overrun done");
    print_verdict();
  end
endmodule // dio_input_capture_start_control_test
`default_nettype wire

// ### bench/dio_periph_model.sv
// Purpose: Peripheral that strobes or handshakes words into the capture block
// Assumes: Word n of a stream is base_i + n * 32'h01010101
// Notes: Runs on its own delays, so its edges have no fixed phase to clk_i
`timescale 1ns/100ps
`default_nettype none
module dio_periph_model (
  // Control from the bench
  input wire logic hs_i,
  input wire logic [15:0] target_i,
  input wire logic [31:0] base_i,
  // Pins
  input wire logic ack_i,
  output logic strobe_o,
  output logic [31:0] data_o,
  // Progress
  output logic [15:0] sent_o
);
  initial begin
    strobe_o = 1'b0;
    data_o = 32'h0;
    sent_o = 16'h0;
  end

  // ==========================================
  // One word per pass; external strobe high 200 ns, low at least 363 ns
  always begin
    wait (sent_o < target_i);
    #13;
    if (hs_i !== 1'b1) begin
      if (ack_i !== 1'b1) wait (ack_i === 1'b1); // Pause while refused
      data_o = base_i + sent_o * 32'h01010101;
      #200 strobe_o = 1'b1; // Data settled 4 clocks before the rise
      #200 strobe_o = 1'b0;
      #150; // Data held past the fall so falling-edge capture sees it
    end else begin
      data_o = base_i + sent_o * 32'h01010101;
      #100 strobe_o = 1'b1; // Data first, then request
      wait (ack_i === 1'b1); // Request held until acknowledged
      #100 strobe_o = 1'b0;
      data_o = ~data_o; // Released data must not look valid
      wait (ack_i !== 1'b1);
      #100;
    end
    sent_o = sent_o + 16'h1;
    if (sent_o >= target_i) data_o = ~data_o;
  end
endmodule // dio_periph_model
`default_nettype wire

// ### core/dio_capture_pkg.sv
// Purpose: Shared constants and types for the digital input capture block
// Assumes: 20 MHz system clock, 32-bit register port
// Notes: Register fields are carried as packed structs
package dio_capture_pkg;
  // ==========================================================
  // Sizes and timing
  localparam int DEPTH = 16384;
  localparam int AW = 14;
  localparam int CW = 15;
  localparam logic [CW-1:0] AFULL_LEVEL = 15'h3FF8;
  localparam int CLK_HZ = 20_000_000;
  localparam int PACE_10M_HZ = 10_000_000;
  localparam int PACE_10M_DIV = CLK_HZ / PACE_10M_HZ;

  // ==========================================================
  // Register map
  localparam logic [3:0] CTRL_OFS = 4'h0;
  localparam logic [3:0] CMD_OFS = 4'h4;
  localparam logic [3:0] THR_OFS = 4'h8;
  localparam logic [3:0] STAT_OFS = 4'hC;
  localparam int CMD_DI_START = 0;
  localparam int CMD_DI_STOP = 1;
  localparam int CMD_DO_START = 2;
  localparam int CMD_DO_STOP = 3;
  localparam int CMD_OVR_CLR = 4;
  localparam int CMD_FLUSH = 5;
  localparam logic [31:0] CTRL_RESET = 32'h0000_0040;
  localparam logic [15:0] THR_RESET = 16'h0100;

  // ==========================================================
  // Field encodings
  typedef enum logic [1:0] {W32, W16, W8, W_RSV} width_t;
  typedef enum logic [1:0] {CLK_INTERNAL, CLK_EXTERNAL, CLK_HANDSHAKE, CLK_RSV} clk_mode_t;
  typedef enum logic [1:0] {PACE_20M, PACE_10M, PACE_TIMER0, PACE_RSV} pacer_t;
  typedef enum logic [1:0] {
    start_immediate, start_on_trigger, start_on_fifo_level, start_on_level_and_trigger
  } start_t;

  typedef struct packed {
    logic [19:0] rsv;
    logic term_en;
    start_t out_start;
    start_t in_start;
    logic rising;
    pacer_t pacer;
    clk_mode_t clk_mode;
    width_t width;
  } ctrl_t;

  typedef struct packed {
    logic valid;
    logic [31:0] data;
  } dma_word_t;
endpackage

// ### core/dio_input_capture_start_control.sv
// Purpose: Digital input capture engine with shared start-trigger logic
// Assumes: Pins are asynchronous and pass two flip-flops; DMA drains dma_o
// Notes: Strobes are found by sampling at clk_i, so edges must be held one clock
`timescale 1ns/100ps
`default_nettype none
module dio_input_capture_start_control (
  // Clock and reset
  input wire logic clk_i,
  input wire logic sys_rst_i,
  // Register port
  input wire logic [3:0] addr_i,
  input wire logic [31:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [31:0] rdata_o,
  // Peripheral pins
  input wire logic [31:0] di_data_i,
  input wire logic input_request_strobe_i,
  input wire logic input_trigger_line_i,
  input wire logic output_trigger_line_i,
  input wire logic timer0_i,
  output logic input_acknowledge_o,
  output logic term_en_o,
  // Output path
  input wire logic [15:0] do_fifo_level_i,
  output logic do_run_o,
  // DMA drain
  input wire logic dma_ready_i,
  output dio_capture_pkg::dma_word_t dma_o
);
  // Assertions below all sit on the system clock and are quiet in reset
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (sys_rst_i);

  // ==========================================================
  // Pin synchronisers
  logic [35:0] s1_q, s2_q;
  logic req_s3_q, itrig_s3_q, otrig_s3_q, tmr_s3_q;
  // First stage feeds only the second stage
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      s1_q <= '0;
      s2_q <= '0;
      {req_s3_q, itrig_s3_q, otrig_s3_q, tmr_s3_q} <= 4'h0;
    end else begin
      s1_q <= {timer0_i, output_trigger_line_i, input_trigger_line_i, input_request_strobe_i, di_data_i};
      s2_q <= s1_q;
      {req_s3_q, itrig_s3_q, otrig_s3_q, tmr_s3_q} <= {s2_q[32], s2_q[33], s2_q[34], s2_q[35]};
    end
  end

  logic req_s, req_rise, req_fall, itrig_edge, otrig_edge, tmr_rise;
  // Edges on the synchronised copies; data and strobe share latency
  assign req_s = s2_q[32];
  assign req_rise = req_s & ~req_s3_q;
  assign req_fall = ~req_s & req_s3_q;
  assign itrig_edge = s2_q[33] & ~itrig_s3_q;
  assign otrig_edge = s2_q[34] & ~otrig_s3_q;
  assign tmr_rise = s2_q[35] & ~tmr_s3_q;

  // ==========================================================
  // Registers
  dio_capture_pkg::ctrl_t ctrl_q, ctrl_d;
  logic [15:0] thr_q, thr_d;
  logic [31:0] rdata_q, rdata_d;
  logic [31:0] cmd;
  logic [31:0] status;
  logic ovr_q, ovr_d;
  logic in_pend_q, in_pend_d, in_run_q, in_run_d;
  logic out_pend_q, out_pend_d, out_run_q, out_run_d, otrig_seen_q, otrig_seen_d;
  logic [dio_capture_pkg::CW-1:0] cnt_q, cnt_d;
  logic push_req, full;

  // Command bits are pulses; they exist only for one write
  assign cmd = (wr_i && addr_i == dio_capture_pkg::CMD_OFS) ? wdata_i : 32'h0000_0000;
  assign full = (cnt_q == dio_capture_pkg::CW'(dio_capture_pkg::DEPTH));
  assign status = {1'b0, cnt_q, 11'h000, full, out_run_q, in_pend_q, in_run_q, ovr_q};

  // Register writes and the read mux; read data valid only the next cycle
  always_comb begin
    ctrl_d = ctrl_q;
    thr_d = thr_q;
    rdata_d = 32'h0000_0000;
    if (wr_i && addr_i == dio_capture_pkg::CTRL_OFS) ctrl_d = wdata_i;
    if (wr_i && addr_i == dio_capture_pkg::THR_OFS) thr_d = wdata_i[15:0];
    if (rd_i) begin
      unique case (addr_i)
        dio_capture_pkg::CTRL_OFS: rdata_d = ctrl_q;
        dio_capture_pkg::THR_OFS: rdata_d = {16'h0000, thr_q};
        dio_capture_pkg::STAT_OFS: rdata_d = status;
        default: rdata_d = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      ctrl_q <= dio_capture_pkg::CTRL_RESET;
      thr_q <= dio_capture_pkg::THR_RESET;
      rdata_q <= 32'h0000_0000;
    end else begin
      ctrl_q <= ctrl_d;
      thr_q <= thr_d;
      rdata_q <= rdata_d;
    end
  end

  // ==========================================================
  // Start control
  // Input treats the FIFO-level codes as immediate, they do not apply there
  always_comb begin
    in_pend_d = in_pend_q;
    in_run_d = in_run_q;
    out_pend_d = out_pend_q;
    out_run_d = out_run_q;
    otrig_seen_d = otrig_seen_q;
    if (in_pend_q && (ctrl_q.in_start != dio_capture_pkg::start_on_trigger || itrig_edge)) begin
      in_pend_d = 1'b0;
      in_run_d = 1'b1;
    end
    if (cmd[dio_capture_pkg::CMD_DI_START]) begin
      in_pend_d = 1'b1;
      in_run_d = 1'b0;
    end
    if (cmd[dio_capture_pkg::CMD_DI_STOP]) begin
      in_pend_d = 1'b0;
      in_run_d = 1'b0;
    end
    if (out_pend_q && otrig_edge) otrig_seen_d = 1'b1;
    if (out_pend_q) begin
      unique case (ctrl_q.out_start)
        dio_capture_pkg::start_immediate: out_run_d = 1'b1;
        dio_capture_pkg::start_on_trigger: out_run_d = otrig_edge;
        dio_capture_pkg::start_on_fifo_level: out_run_d = (do_fifo_level_i >= thr_q);
        dio_capture_pkg::start_on_level_and_trigger:
          out_run_d = (do_fifo_level_i >= thr_q) && (otrig_seen_q || otrig_edge);
      endcase
      if (out_run_d) out_pend_d = 1'b0;
    end
    if (cmd[dio_capture_pkg::CMD_DO_START]) begin
      out_pend_d = 1'b1;
      out_run_d = 1'b0;
      otrig_seen_d = 1'b0;
    end
    if (cmd[dio_capture_pkg::CMD_DO_STOP]) begin
      out_pend_d = 1'b0;
      out_run_d = 1'b0;
    end
  end

  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      {in_pend_q, in_run_q, out_pend_q, out_run_q, otrig_seen_q} <= 5'h00;
    end else begin
      {in_pend_q, in_run_q, out_pend_q, out_run_q, otrig_seen_q} <=
        {in_pend_d, in_run_d, out_pend_d, out_run_d, otrig_seen_d};
    end
  end

  imm_start_a: assert property (cmd[dio_capture_pkg::CMD_DI_START] && !cmd[dio_capture_pkg::CMD_DI_STOP]
    ##1 ctrl_q.in_start == dio_capture_pkg::start_immediate && !cmd[dio_capture_pkg::CMD_DI_STOP]
    && !cmd[dio_capture_pkg::CMD_DI_START] |=> in_run_q) else $error("input did not start at once");
  trig_hold_a: assert property (in_pend_q && ctrl_q.in_start == dio_capture_pkg::start_on_trigger
    && !itrig_edge && !cmd[dio_capture_pkg::CMD_DI_START] |=> !in_run_q) else $error("input started early");
  in_fifo_mode_a: assert property (in_pend_q && ctrl_q.in_start[1] && !cmd[dio_capture_pkg::CMD_DI_START]
    && !cmd[dio_capture_pkg::CMD_DI_STOP] |=> in_run_q) else $error("input waited on level mode");
  out_level_a: assert property (out_pend_q && ctrl_q.out_start == dio_capture_pkg::start_on_fifo_level
    && do_fifo_level_i < thr_q |=> !do_run_o) else $error("output started below level");
  out_both_a: assert property (out_pend_q && ctrl_q.out_start == dio_capture_pkg::start_on_level_and_trigger
    && !otrig_seen_q && !otrig_edge |=> !do_run_o) else $error("output started without trigger");

  // ==========================================================
  // Sample pacing and capture
  typedef enum logic {HS_WAIT, HS_ACK} hs_t;
  hs_t hs_q, hs_d;
  logic div_q, div_d, ack_q, ack_d;
  logic tick;
  logic [31:0] sample;
  // A divide of one would leave the 10 MHz pacer ticking every clock
  localparam bit PACE_DIV_WRAP = (dio_capture_pkg::PACE_10M_DIV < 2);

  // Narrow widths keep the low lanes; upper bits stored as zero
  always_comb begin
    unique case (ctrl_q.width)
      dio_capture_pkg::W16: sample = {16'h0000, s2_q[15:0]};
      dio_capture_pkg::W8: sample = {24'h000000, s2_q[7:0]};
      default: sample = s2_q[31:0];
    endcase
  end

  // Pacer sources for internal clock mode
  always_comb begin
    unique case (ctrl_q.pacer)
      dio_capture_pkg::PACE_20M: tick = 1'b1;
      dio_capture_pkg::PACE_10M: tick = div_q;
      dio_capture_pkg::PACE_TIMER0: tick = tmr_rise;
      default: tick = 1'b0;
    endcase
  end

  // Capture sources and acknowledge per clocking mode
  always_comb begin
    div_d = (PACE_DIV_WRAP) ? 1'b1 : ~div_q;
    hs_d = hs_q;
    ack_d = 1'b0;
    push_req = 1'b0;
    unique case (ctrl_q.clk_mode)
      dio_capture_pkg::CLK_INTERNAL: push_req = in_run_q && tick;
      dio_capture_pkg::CLK_EXTERNAL: begin
        push_req = in_run_q && (ctrl_q.rising ? req_rise : req_fall);
        ack_d = in_run_q && (cnt_d < dio_capture_pkg::AFULL_LEVEL);
      end
      dio_capture_pkg::CLK_HANDSHAKE: begin
        // Request held by the peripheral until acknowledged
        if (hs_q == HS_WAIT && in_run_q && req_s && !full) begin
          push_req = 1'b1;
          hs_d = HS_ACK;
        end else if (hs_q == HS_ACK && !req_s) begin
          hs_d = HS_WAIT;
        end
        ack_d = (hs_d == HS_ACK);
      end
      default: push_req = 1'b0;
    endcase
    if (ctrl_q.clk_mode != dio_capture_pkg::CLK_HANDSHAKE) hs_d = HS_WAIT;
  end

  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      hs_q <= HS_WAIT;
      div_q <= 1'b0;
      ack_q <= 1'b0;
    end else begin
      hs_q <= hs_d;
      div_q <= div_d;
      ack_q <= ack_d;
    end
  end

  hs_hold_a: assert property (ctrl_q.clk_mode == dio_capture_pkg::CLK_HANDSHAKE && input_acknowledge_o
    && req_s && $stable(ctrl_q) |=> input_acknowledge_o) else $error("acknowledge dropped early");
  ack_ext_a: assert property (ctrl_q.clk_mode == dio_capture_pkg::CLK_EXTERNAL && !pop
    && !cmd[dio_capture_pkg::CMD_FLUSH] && cnt_q >= dio_capture_pkg::AFULL_LEVEL |=> !input_acknowledge_o)
    else $error("acknowledge high near full");

  // ==========================================================
  // Input FIFO and DMA drain
  logic [31:0] mem_q [dio_capture_pkg::DEPTH];
  logic [dio_capture_pkg::AW-1:0] wptr_q, wptr_d, rptr_q, rptr_d;
  logic dvalid_q, dvalid_d;
  logic [31:0] ddata_q;
  logic push, pop;

  // DMA draws do not touch the FIFO beyond the words taken
  assign push = push_req && !full;
  assign pop = (cnt_q != '0) && (!dvalid_q || dma_ready_i);

  // Overrun set wins over a clear or restart in the same cycle
  always_comb begin
    wptr_d = wptr_q + dio_capture_pkg::AW'(push);
    rptr_d = rptr_q + dio_capture_pkg::AW'(pop);
    cnt_d = cnt_q + dio_capture_pkg::CW'(push) - dio_capture_pkg::CW'(pop);
    dvalid_d = pop || (dvalid_q && !dma_ready_i);
    ovr_d = ovr_q;
    if (cmd[dio_capture_pkg::CMD_OVR_CLR] || cmd[dio_capture_pkg::CMD_DI_START]) ovr_d = 1'b0;
    if (push_req && full) ovr_d = 1'b1;
    if (cmd[dio_capture_pkg::CMD_FLUSH]) begin
      wptr_d = '0;
      rptr_d = '0;
      cnt_d = '0;
      dvalid_d = 1'b0;
    end
  end

  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      wptr_q <= '0;
      rptr_q <= '0;
      cnt_q <= '0;
      dvalid_q <= 1'b0;
      ovr_q <= 1'b0;
    end else begin
      wptr_q <= wptr_d;
      rptr_q <= rptr_d;
      cnt_q <= cnt_d;
      dvalid_q <= dvalid_d;
      ovr_q <= ovr_d;
    end
  end

  // Storage has no reset; contents are only read behind the count
  always_ff @(posedge clk_i) begin
    if (push) mem_q[wptr_q] <= sample;
    if (pop) ddata_q <= mem_q[rptr_q];
  end

  ovr_set_a: assert property (push_req && full |=> ovr_q) else $error("overrun not flagged");
  full_drop_a: assert property (push_req && full && !pop && !cmd[dio_capture_pkg::CMD_FLUSH]
    |=> cnt_q == $past(cnt_q)) else $error("sample written into full fifo");
  ovr_sticky_a: assert property (ovr_q && !cmd[dio_capture_pkg::CMD_OVR_CLR]
    && !cmd[dio_capture_pkg::CMD_DI_START] |=> ovr_q) else $error("overrun lost");

  // ==========================================================
  // Outputs
  assign rdata_o = rdata_q;
  assign input_acknowledge_o = ack_q;
  assign term_en_o = ctrl_q.term_en;
  assign do_run_o = out_run_q;
  assign dma_o = {dvalid_q, ddata_q};
endmodule // dio_input_capture_start_control
`default_nettype wire
